// ### bench/eamg_assertions.sv
// Port checker for the address generator.
// Assumes one clock domain; attached by the bind at the foot.
`include "eamg_consts.vh"
module eamg_checker (
	input logic sys_clk,
	input logic reset,
	input logic req_valid,
	input logic [3:0] req_mode,
	input logic [3:0] pointer_register,
	input logic [15:0] pointer_value,
	input logic [15:0] req_literal,
	input logic [2:0] dsp_op,
	input logic dest_to_default_working_register,
	input logic [15:0] ea,
	input logic ea_valid,
	input logic [1:0] ea_gen,
	input logic [15:0] operand,
	input logic operand_valid,
	input logic [3:0] wb_index,
	input logic wb_en,
	input logic [15:0] wb_value,
	input logic default_working_register_zero_dest,
	input logic dsp_error
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	// ====
	// Request answers
	a_file_addr: assert property (req_valid && req_mode == `EAMG_M_FILE
		|=> ea_valid && ea == ($past(req_literal) & 16'h1FFF)) else $error("file address wrong");
	a_file_dest: assert property (req_valid && req_mode == `EAMG_M_FILE
		|=> default_working_register_zero_dest == $past(dest_to_default_working_register)) else $error("file destination wrong");
	a_ind_plain: assert property (req_valid && req_mode == `EAMG_M_IND
		|=> ea_valid && !wb_en && ea == $past(pointer_value)) else $error("indirect wrong");
	a_post_old: assert property (req_valid && req_mode == `EAMG_M_POST
		|=> ea_valid && wb_en && ea == $past(pointer_value)) else $error("post modify wrong");
	a_pre_same: assert property (req_valid && req_mode == `EAMG_M_PRE
		|=> ea_valid && wb_en && ea == wb_value) else $error("pre modify wrong");
	a_offset_nowb: assert property (req_valid && (req_mode == `EAMG_M_IDX
		|| req_mode == `EAMG_M_LITOFS) |=> ea_valid && !wb_en) else $error("offset wrote back");
	// Only pointers 8 to 11 may feed the dual-operand path.
	a_dsp_refuse: assert property (req_valid && req_mode == `EAMG_M_DSP
		&& pointer_register[3:2] != 2'h2 |=> dsp_error && !ea_valid && !wb_en)
		else $error("bad dsp pointer taken");
	a_dsp_space: assert property (req_valid && req_mode == `EAMG_M_DSP
		&& pointer_register[3:2] == 2'h2 && dsp_op != 3'h7
		|=> ea_valid && ea_gen == {$past(pointer_register[1]), 1'h0}) else $error("dsp space wrong");
	a_dsp_index: assert property (req_valid && req_mode == `EAMG_M_DSP
		&& dsp_op == 3'h7 && pointer_register[3:2] == 2'h2 && !pointer_register[0]
		|=> dsp_error && !ea_valid) else $error("dsp index on bad pointer");
	a_wb_index: assert property (req_valid && (req_mode == `EAMG_M_POST
		|| req_mode == `EAMG_M_PRE) |=> wb_en && wb_index == $past(pointer_register))
		else $error("write-back index wrong");
	a_lit5_operand: assert property (req_valid && req_mode == `EAMG_M_LIT5
		|=> operand_valid && operand == ($past(req_literal) & 16'h001F))
		else $error("short literal wrong");
	a_branch_operand: assert property (req_valid && req_mode == `EAMG_M_BRANCH
		|=> operand_valid && operand == $past(req_literal)) else $error("branch literal wrong");
endmodule

bind eamg_agu eamg_checker chk (.sys_clk(sys_clk), .reset(reset), .req_valid(req_valid),
	.req_mode(req_mode), .pointer_register(pointer_register), .pointer_value(pointer_value),
	.req_literal(req_literal), .dsp_op(dsp_op), .dest_to_default_working_register(dest_to_default_working_register), .ea(ea),
	.ea_valid(ea_valid), .ea_gen(ea_gen), .operand(operand), .operand_valid(operand_valid),
	.wb_index(wb_index), .wb_en(wb_en), .wb_value(wb_value),
	.default_working_register_zero_dest(default_working_register_zero_dest), .dsp_error(dsp_error));

// ### bench/eamg_default_working_register_model.sv
// Working-register file on the decoder side of the generator.
// Assumes the bench loads a register before any request reads it.
module eamg_default_working_register_model (
	input logic sys_clk,
	input logic ld_en,
	input logic [3:0] ld_index,
	input logic [15:0] ld_value,
	input logic [3:0] rd_index,
	output logic [15:0] rd_value,
	input logic wb_en,
	input logic [3:0] wb_index,
	input logic [15:0] wb_value
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] wr [16];
	// Unloaded registers stay unknown so a stray read cannot pass by luck.
	assign rd_value = wr[rd_index];
	always @(posedge sys_clk) begin
		if (wb_en)
			wr[wb_index] <= wb_value;
		if (ld_en)
			wr[ld_index] <= ld_value;
	end
endmodule

// ### bench/tb_effective_address_modulo_gen.sv
// Self-checking bench for the address generator.
// Assumes the register-file model and the checker are compiled first.
`include "eamg_consts.vh"
module tb_effective_address_modulo_gen;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = '0, reset = 1'h1, reg_wr = '0, reg_rd = '0, req_valid = '0, rd_seen = '0;
	logic dest_to_default_working_register = '0, bitrev_active = '0, ld_en = '0;
	logic [2:0] reg_addr = '0, dsp_op = '0;
	logic [1:0] req_gen = '0, ea_gen;
	logic [3:0] req_mode = '0, pointer_register = '0, ld_index = '0, wb_index;
	logic [15:0] reg_wdata = '0, base_register = '0, req_literal = '0, req_modifier = '0;
	logic [15:0] ld_value = '0, pointer_value, reg_rdata, ea, operand, wb_value;
	logic ea_valid, operand_valid, wb_en, default_working_register_zero_dest, dsp_error;
	logic [15:0] q_ea[$], q_wb[$], q_rd[$], q_op[$];
	logic [31:0] lfsr = 32'h8a0e_9eae;
	int fail_count = 0, checks_done = 0;
	always #50 sys_clk = ~sys_clk;
	eamg_agu DUT (.*);
	eamg_default_working_register_model wrf (.sys_clk(sys_clk), .ld_en(ld_en), .ld_index(ld_index),
		.ld_value(ld_value), .rd_index(pointer_register), .rd_value(pointer_value),
		.wb_en(wb_en), .wb_index(wb_index), .wb_value(wb_value));
	// ====
	// Helpers
	function automatic logic [31:0] next_rand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic rw(input logic wr, input logic [2:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_wr <= wr;
		reg_rd <= !wr;
		reg_addr <= a;
		reg_wdata <= d;
		if (!wr)
			q_rd.push_back(d);
		@(posedge sys_clk);
		reg_wr <= 1'h0;
		reg_rd <= 1'h0;
	endtask
	task automatic ld(input logic [3:0] i, input logic [15:0] v);
		@(posedge sys_clk);
		ld_en <= 1'h1;
		ld_index <= i;
		ld_value <= v;
		@(posedge sys_clk);
		ld_en <= 1'h0;
	endtask
	task automatic rq(input logic [1:0] g, input logic [3:0] m, input logic [3:0] p,
		input logic [15:0] b, input logic [15:0] l, input logic [2:0] op,
		input logic [15:0] e, input logic [15:0] w, input logic he, input logic hw);
		@(posedge sys_clk);
		req_valid <= 1'h1;
		req_gen <= g;
		req_mode <= m;
		pointer_register <= p;
		base_register <= b;
		req_modifier <= b;
		req_literal <= l;
		dsp_op <= op;
		if (he)
			q_ea.push_back(e);
		if (hw)
			q_wb.push_back(w);
		@(posedge sys_clk);
		req_valid <= 1'h0;
	endtask
	task automatic op(input logic [3:0] m, input logic [3:0] p, input logic [15:0] l,
		input logic [15:0] e);
		@(posedge sys_clk);
		req_valid <= 1'h1;
		req_mode <= m;
		pointer_register <= p;
		req_literal <= l;
		q_op.push_back(e);
		@(posedge sys_clk);
		req_valid <= 1'h0;
	endtask
	// ====
	// Result watcher
	always @(posedge sys_clk) begin
		if (rd_seen)
			cmp(reg_rdata, q_rd.pop_front(), "read data");
		if (ea_valid)
			cmp(ea, q_ea.pop_front(), "address");
		if (wb_en)
			cmp(wb_value, q_wb.pop_front(), "write-back");
		if (operand_valid)
			cmp(operand, q_op.pop_front(), "operand");
		rd_seen <= reg_rd;
	end
	// ====
	// Scenarios
	initial begin
		int st;
		logic ok;
		repeat (5) @(posedge sys_clk);
		reset <= 1'h0;
		rw(0, `EAMG_OFS_CTRL, `EAMG_CTRL_RST);
		rw(0, 3'h6, 16'h0000);
		rw(1, `EAMG_OFS_XSTART, 16'h0100);
		rw(1, `EAMG_OFS_XEND, 16'h010F);
		rw(0, `EAMG_OFS_XEND, 16'h010F);
		$display("registers done");
		ld(4'h2, 16'h0100);
		rq(0, `EAMG_M_IND, 2, 16'h0004, 0, 0, 16'h0100, 0, 1, 0);
		rq(0, `EAMG_M_POST, 2, 16'h0004, 0, 0, 16'h0100, 16'h0104, 1, 1);
		rq(0, `EAMG_M_PRE, 2, 16'hFFFE, 0, 0, 16'h0102, 16'h0102, 1, 1);
		rq(0, `EAMG_M_IDX, 2, 16'h0010, 0, 0, 16'h0112, 0, 1, 0);
		rq(0, `EAMG_M_LITOFS, 2, 0, 16'h0020, 0, 16'h0122, 0, 1, 0);
		for (int i = 0; i < 4; i++) begin
			lfsr = next_rand(lfsr);
			dest_to_default_working_register <= lfsr[15];
			rq(0, `EAMG_M_FILE, 0, 0, lfsr[15:0], 0, {3'h0, lfsr[12:0]}, 0, 1, 0);
		end
		ld(4'h5, lfsr[31:16]);
		op(`EAMG_M_REGDIR, 4'h5, 0, lfsr[31:16]);
		lfsr = next_rand(lfsr);
		op(`EAMG_M_LIT5, 0, lfsr[15:0], {11'h0, lfsr[4:0]});
		op(`EAMG_M_BRANCH, 0, lfsr[31:16], lfsr[31:16]);
		op(`EAMG_M_INTERRUPT_DISABLE_INSTRUCTION, 0, lfsr[15:0], {2'h0, lfsr[13:0]});
		$display("plain modes done");
		for (int p = 8; p < 12; p++)
			for (int o = 0; o < 8; o++) begin
				ld(p[3:0], 16'h0400);
				ok = o != 7 || p[0];
				st = (o == 0 || o == 7) ? 0 : (o < 4 ? 2 * o : -2 * (o - 3));
				rq(0, `EAMG_M_DSP, p[3:0], 16'h0008, 0, o[2:0], (o == 7) ? 16'h0408 : 16'h0400,
					16'h0400 + st, ok, st != 0);
			end
		rq(0, `EAMG_M_DSP, 3, 0, 0, 0, 0, 0, 0, 0);
		$display("dual-operand done");
		rw(1, `EAMG_OFS_CTRL, 16'h8002);
		ld(4'h2, 16'h010C);
		rq(0, `EAMG_M_POST, 2, 16'h0004, 0, 0, 16'h010C, 16'h0100, 1, 1);
		rq(0, `EAMG_M_POST, 2, 16'h0004, 0, 0, 16'h0100, 16'h0104, 1, 1);
		rq(0, `EAMG_M_PRE, 2, 16'hFFF8, 0, 0, 16'h010C, 16'h010C, 1, 1);
		rq(0, `EAMG_M_IDX, 2, 16'h0008, 0, 0, 16'h0104, 0, 1, 0);
		bitrev_active <= 1'h1;
		rq(1, `EAMG_M_POST, 2, 16'h0004, 0, 0, 16'h010C, 16'h0110, 1, 1);
		ld(4'h2, 16'h010C);
		rq(0, `EAMG_M_POST, 2, 16'h0004, 0, 0, 16'h010C, 16'h0100, 1, 1);
		bitrev_active <= 1'h0;
		rw(1, `EAMG_OFS_CTRL, 16'h800F);
		rq(0, `EAMG_M_POST, 2, 16'h0010, 0, 0, 16'h0100, 16'h0110, 1, 1);
		rw(1, `EAMG_OFS_CTRL, 16'h403F);
		rw(1, `EAMG_OFS_YSTART, 16'h0200);
		rw(1, `EAMG_OFS_YEND, 16'h021F);
		ld(4'h3, 16'h021E);
		rq(2, `EAMG_M_POST, 3, 16'h0005, 0, 0, 16'h021E, 16'h0202, 1, 1);
		rw(0, `EAMG_OFS_STATUS, 16'h0002);
		$display("circular done");
		repeat (3) @(posedge sys_clk);
		results();
	end
	initial begin
		#500_000;
		fail_count++;
		$display("ERROR %0t watchdog expired", $time);
		results();
	end
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0 && q_ea.size() == 0 && q_wb.size() == 0
			&& q_rd.size() == 0 && q_op.size() == 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
endmodule

// ### inc/eamg_consts.vh
// Constants for the effective-address and circular-buffer generator.
// Assumes a 16-bit data path and a 3-bit register port address.
`ifndef EAMG_CONSTS_VH
`define EAMG_CONSTS_VH

// ====================================================================
// Register offsets
`define EAMG_OFS_CTRL 3'h0
`define EAMG_OFS_XSTART 3'h1
`define EAMG_OFS_XEND 3'h2
`define EAMG_OFS_YSTART 3'h3
`define EAMG_OFS_YEND 3'h4
`define EAMG_OFS_STATUS 3'h5

// ====================================================================
// Control fields and reset values
`define EAMG_BIT_XEN 15
`define EAMG_BIT_YEN 14
`define EAMG_XSEL_HI 3
`define EAMG_XSEL_LO 0
`define EAMG_YSEL_HI 7
`define EAMG_YSEL_LO 4
`define EAMG_SEL_OFF 4'hF
`define EAMG_CTRL_RST 16'h00FF
`define EAMG_BUF_RST 16'h0000

// ====================================================================
// Generator selects
`define EAMG_GEN_XR 2'h0
`define EAMG_GEN_XW 2'h1
`define EAMG_GEN_Y 2'h2

// ====================================================================
// Addressing modes
`define EAMG_M_FILE 4'h0
`define EAMG_M_REGDIR 4'h1
`define EAMG_M_IND 4'h2
`define EAMG_M_POST 4'h3
`define EAMG_M_PRE 4'h4
`define EAMG_M_IDX 4'h5
`define EAMG_M_LITOFS 4'h6
`define EAMG_M_DSP 4'h7
`define EAMG_M_LIT5 4'h8
`define EAMG_M_BRANCH 4'h9
`define EAMG_M_INTERRUPT_DISABLE_INSTRUCTION 4'hA

// ====================================================================
// Dual-operand sub-operations
`define EAMG_DSP_IND 3'h0
`define EAMG_DSP_INC2 3'h1
`define EAMG_DSP_INC4 3'h2
`define EAMG_DSP_INC6 3'h3
`define EAMG_DSP_DEC2 3'h4
`define EAMG_DSP_DEC4 3'h5
`define EAMG_DSP_DEC6 3'h6
`define EAMG_DSP_IDX 3'h7
`define EAMG_DSP_PTR_HI 2'h2

`endif

// ### verilog/eamg_agu.v
// Effective-address generator with X and Y circular-buffer correction.
// Assumes the decoder presents one request per cycle with register values
// already read from the working-register file.
//
// What this block does
// - File-direct: 13-bit field addresses first 8192 bytes.
// - File ops take working register zero as destination when the request asks for it.
// - First source register direct; second register/memory/5-bit literal.
// - Indirect: address is unmodified pointer.
// - Post-modify: use pointer, then step it.
// - Pre-modify: step pointer by signed constant, use it.
// - Indexed adds base register; literal offset adds literal.
// - Move source and destination share one base field.
// - Dual-operand pointers 8-11; 8,9 X read, 10,11 Y.
// - Dual-operand indexed only through pointers 9 and 11.
// - Dual-operand: indirect, indexed, post-modify by 2/4/6.
// - Branch 16-bit signed literal; interrupt-disable 14-bit unsigned.
// - One X and one Y buffer, any pointer but 15.
// - Power-of-two buffers checked at both boundaries.
// - Length from 16-bit start/end, up to 32K words.
// - Y circular corrected addresses always word aligned; indirect and post-modify put out the pointer as read.
// - X circular needs control bit 15 and select.
// - Y circular needs control bit 14 and select.
// - Boundaries test beyond, not only equal.
// - Corrected pointer written back only for pre/post modify.
// - Bit-reverse disables circular on X write only.
//
// Local design decisions: the address map and the strobed register port.
`include "eamg_consts.vh"

module eamg_agu (
	input wire sys_clk,
	input wire reset,
	input wire [2:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [15:0] reg_rdata,
	input wire req_valid,
	input wire [1:0] req_gen,
	input wire [3:0] req_mode,
	input wire [3:0] pointer_register,
	input wire [15:0] pointer_value,
	input wire [15:0] base_register,
	input wire [15:0] req_literal,
	input wire [15:0] req_modifier,
	input wire [2:0] dsp_op,
	input wire dest_to_default_working_register,
	input wire bitrev_active,
	output reg [15:0] ea,
	output reg ea_valid,
	output reg [1:0] ea_gen,
	output reg [15:0] operand,
	output reg operand_valid,
	output reg wb_en,
	output reg [3:0] wb_index,
	output reg [15:0] wb_value,
	output reg default_working_register_zero_dest,
	output reg dsp_error
);

	// ====================================================================
	// Circular fold, shared by the X and Y generators
	function [16:0] eamg_fold;
		input [15:0] a;
		input [15:0] s;
		input [15:0] e;
		input up;
		input ysp;
		reg [16:0] len;
		reg p2;
		reg [15:0] r;
		reg w;
		begin
			len = {1'b0, e} - {1'b0, s} + 17'h0_0001;
			p2 = (len & (len - 17'h0_0001)) == 17'h0_0000;
			r = a;
			w = 1'b0;
			// A power-of-two buffer meets both alignment limits, so it can run either way.
			if ((up || p2) && a > e) begin
				r = a - len[15:0];
				w = 1'b1;
			end else if ((!up || p2) && a < s) begin
				r = a + len[15:0];
				w = 1'b1;
			end
			if (ysp)
				r[0] = 1'b0;
			eamg_fold = {w, r};
		end
	endfunction

	// ====================================================================
	// Circular select: an enabled space whose select names this pointer
	function eamg_circ_hit;
		input en;
		input [3:0] sel;
		input [3:0] ptr;
		begin
			// Select value 15 parks the space, so no pointer can wrap by accident.
			eamg_circ_hit = en && sel != `EAMG_SEL_OFF && ptr == sel;
		end
	endfunction

	// ====================================================================
	// Dual-operand step: fixed post-modify constants or the shared base
	function [15:0] eamg_dsp_step;
		input [2:0] op;
		input [15:0] base;
		begin
			case (op)
				`EAMG_DSP_INC2: begin
					eamg_dsp_step = 16'h0002;
				end
				`EAMG_DSP_INC4: begin
					eamg_dsp_step = 16'h0004;
				end
				`EAMG_DSP_INC6: begin
					eamg_dsp_step = 16'h0006;
				end
				`EAMG_DSP_DEC2: begin
					eamg_dsp_step = 16'hFFFE;
				end
				`EAMG_DSP_DEC4: begin
					eamg_dsp_step = 16'hFFFC;
				end
				`EAMG_DSP_DEC6: begin
					eamg_dsp_step = 16'hFFFA;
				end
				`EAMG_DSP_IDX: begin
					eamg_dsp_step = base;
				end
				default: begin
					eamg_dsp_step = 16'h0000;
				end
			endcase
		end
	endfunction

	// ====================================================================
	// Register read mux; unmapped indices read as zero
	function [15:0] eamg_reg_read;
		input [2:0] a;
		input [15:0] ctrl;
		input [15:0] xs;
		input [15:0] xe;
		input [15:0] ys;
		input [15:0] ye;
		input [1:0] wrap;
		begin
			case (a)
				`EAMG_OFS_CTRL: begin
					eamg_reg_read = ctrl;
				end
				`EAMG_OFS_XSTART: begin
					eamg_reg_read = xs;
				end
				`EAMG_OFS_XEND: begin
					eamg_reg_read = xe;
				end
				`EAMG_OFS_YSTART: begin
					eamg_reg_read = ys;
				end
				`EAMG_OFS_YEND: begin
					eamg_reg_read = ye;
				end
				`EAMG_OFS_STATUS: begin
					eamg_reg_read = {14'h0, wrap};
				end
				default: begin
					eamg_reg_read = 16'h0000;
				end
			endcase
		end
	endfunction

	// ====================================================================
	// Registers
	reg [15:0] circular_addressing_control;
	reg [15:0] x_buffer_start_address;
	reg [15:0] x_buffer_end_address;
	reg [15:0] y_buffer_start_address;
	reg [15:0] y_buffer_end_address;
	reg [1:0] last_wrap;

	wire [3:0] x_pointer_select;
	wire [3:0] y_pointer_select;
	wire x_circular_enable;
	wire y_circular_enable;
	assign x_pointer_select = circular_addressing_control[`EAMG_XSEL_HI:`EAMG_XSEL_LO];
	assign y_pointer_select = circular_addressing_control[`EAMG_YSEL_HI:`EAMG_YSEL_LO];
	assign x_circular_enable = circular_addressing_control[`EAMG_BIT_XEN];
	assign y_circular_enable = circular_addressing_control[`EAMG_BIT_YEN];

	always @(posedge sys_clk) begin
		if (reset) begin
			circular_addressing_control <= `EAMG_CTRL_RST;
			x_buffer_start_address <= `EAMG_BUF_RST;
			x_buffer_end_address <= `EAMG_BUF_RST;
			y_buffer_start_address <= `EAMG_BUF_RST;
			y_buffer_end_address <= `EAMG_BUF_RST;
			reg_rdata <= 16'h0000;
		end else begin
			if (reg_wr) begin
				case (reg_addr)
					`EAMG_OFS_CTRL: circular_addressing_control <= reg_wdata;
					`EAMG_OFS_XSTART: x_buffer_start_address <= reg_wdata;
					`EAMG_OFS_XEND: x_buffer_end_address <= reg_wdata;
					`EAMG_OFS_YSTART: y_buffer_start_address <= reg_wdata;
					`EAMG_OFS_YEND: y_buffer_end_address <= reg_wdata;
					default: ;
				endcase
			end
			if (reg_rd) begin
				reg_rdata <= eamg_reg_read(reg_addr, circular_addressing_control,
					x_buffer_start_address, x_buffer_end_address, y_buffer_start_address,
					y_buffer_end_address, last_wrap);
			end else begin
				reg_rdata <= 16'h0000;
			end
		end
	end

	// ====================================================================
	// Address calculation
	reg [1:0] gen;
	reg legal;
	reg [15:0] step;
	reg [15:0] sum;
	reg modify;
	reg offset;
	reg up;
	reg circ_x;
	reg circ_y;
	reg [16:0] folded;
	reg [15:0] fixed;
	reg [15:0] next_ea;
	reg next_ea_valid;
	reg [15:0] next_operand;
	reg next_operand_valid;
	reg next_wb_en;
	reg [15:0] next_wb_value;
	reg next_default_working_register_zero;
	reg [1:0] next_wrap;

	always @* begin
		gen = req_gen;
		legal = 1'b1;
		step = req_modifier;
		modify = 1'b0;
		offset = 1'b0;
		if (req_mode == `EAMG_M_DSP) begin
			// Only pointers 8 to 11 reach the dual-operand path; bit 1 picks the space.
			legal = pointer_register[3:2] == `EAMG_DSP_PTR_HI;
			gen = pointer_register[1] ? `EAMG_GEN_Y : `EAMG_GEN_XR;
			step = eamg_dsp_step(dsp_op, base_register);
			if (dsp_op == `EAMG_DSP_IDX) begin
				legal = legal && pointer_register[0];
			end
			modify = dsp_op != `EAMG_DSP_IND && dsp_op != `EAMG_DSP_IDX;
			offset = dsp_op == `EAMG_DSP_IDX;
		end else if (req_mode == `EAMG_M_IDX) begin
			step = base_register;
			offset = 1'b1;
		end else if (req_mode == `EAMG_M_LITOFS) begin
			step = req_literal;
			offset = 1'b1;
		end else begin
			modify = req_mode == `EAMG_M_POST || req_mode == `EAMG_M_PRE;
		end
		sum = pointer_value + step;
		up = !step[15];
		circ_x = eamg_circ_hit(x_circular_enable, x_pointer_select, pointer_register)
			&& gen != `EAMG_GEN_Y
			&& !(gen == `EAMG_GEN_XW && bitrev_active);
		circ_y = eamg_circ_hit(y_circular_enable, y_pointer_select, pointer_register)
			&& gen == `EAMG_GEN_Y;
		if (circ_y)
			folded = eamg_fold(sum, y_buffer_start_address, y_buffer_end_address, up, 1'b1);
		else if (circ_x)
			folded = eamg_fold(sum, x_buffer_start_address, x_buffer_end_address, up, 1'b0);
		else
			folded = {1'b0, sum};
		fixed = (modify || offset) ? folded[15:0] : sum;
		next_wrap = (modify || offset) && folded[16] ? {circ_y, circ_x} : 2'b00;
		next_ea = 16'h0000;
		next_ea_valid = 1'b0;
		next_operand = 16'h0000;
		next_operand_valid = 1'b0;
		next_wb_en = 1'b0;
		next_wb_value = fixed;
		next_default_working_register_zero = 1'b0;
		case (req_mode)
			`EAMG_M_FILE: begin
				next_ea = {3'b000, req_literal[12:0]};
				next_ea_valid = 1'b1;
				next_default_working_register_zero = dest_to_default_working_register;
			end
			`EAMG_M_REGDIR: begin
				next_operand = pointer_value;
				next_operand_valid = 1'b1;
			end
			`EAMG_M_IND: begin
				next_ea = pointer_value;
				next_ea_valid = 1'b1;
			end
			`EAMG_M_POST: begin
				next_ea = pointer_value;
				next_ea_valid = 1'b1;
				next_wb_en = 1'b1;
			end
			`EAMG_M_PRE: begin
				next_ea = fixed;
				next_ea_valid = 1'b1;
				next_wb_en = 1'b1;
			end
			`EAMG_M_IDX, `EAMG_M_LITOFS: begin
				next_ea = fixed;
				next_ea_valid = 1'b1;
			end
			`EAMG_M_DSP: begin
				next_ea = offset ? fixed : pointer_value;
				next_ea_valid = legal;
				next_wb_en = legal && modify;
			end
			`EAMG_M_LIT5: begin
				next_operand = {11'h0, req_literal[4:0]};
				next_operand_valid = 1'b1;
			end
			`EAMG_M_BRANCH: begin
				next_operand = req_literal;
				next_operand_valid = 1'b1;
			end
			`EAMG_M_INTERRUPT_DISABLE_INSTRUCTION: begin
				next_operand = {2'b00, req_literal[13:0]};
				next_operand_valid = 1'b1;
			end
			default: ;
		endcase
	end

	// ====================================================================
	// Registered answer, one cycle after the request
	always @(posedge sys_clk) begin
		if (reset) begin
			ea <= 16'h0000;
			ea_valid <= 1'b0;
			ea_gen <= `EAMG_GEN_XR;
			operand <= 16'h0000;
			operand_valid <= 1'b0;
			wb_en <= 1'b0;
			wb_index <= 4'h0;
			wb_value <= 16'h0000;
			default_working_register_zero_dest <= 1'b0;
			dsp_error <= 1'b0;
			last_wrap <= 2'b00;
		end else begin
			ea <= next_ea;
			ea_valid <= req_valid && next_ea_valid;
			ea_gen <= gen;
			operand <= next_operand;
			operand_valid <= req_valid && next_operand_valid;
			wb_en <= req_valid && next_wb_en;
			wb_index <= pointer_register;
			wb_value <= next_wb_value;
			default_working_register_zero_dest <= req_valid && next_default_working_register_zero;
			dsp_error <= req_valid && req_mode == `EAMG_M_DSP && !legal;
			if (req_valid)
				last_wrap <= next_wrap;
		end
	end

endmodule
